// file: dv/fos_assertions.sv
// Checker on the pins between the controller and the operand bank.
// Assumes one clock and a synchronous active-high reset, instantiated beside fos_if.
module fos_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic a_bank_select_low,
  input wire logic a_bank_select_high,
  input wire logic b_bank_select_low,
  input wire logic b_bank_select_high,
  input wire logic single_precision_select,
  input wire fos_pkg::fos_instr_t alu_instruction_field,
  input wire logic op_start,
  input wire logic op_unit_alu,
  input wire logic load_a_en,
  input wire fos_pkg::fos_idx_t load_a_idx,
  input wire logic load_b_en,
  input wire fos_pkg::fos_idx_t load_b_idx,
  input wire logic mc_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  import fos_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic mc_op;
  assign mc_op = op_unit_alu && fos_is_multicycle(alu_instruction_field);
  AST_MC_START: assert property (op_start && !mc_busy && mc_op |=> mc_busy)
    else $error("multicycle start without busy");
  AST_SINGLE: assert property (op_start && !mc_busy && !mc_op |=> !mc_busy)
    else $error("ordinary operation went multicycle");
  AST_MC_LEN: assert property ($rose(mc_busy) |-> mc_busy [*7] ##1 !mc_busy)
    else $error("busy length wrong");
  AST_BUSY_CAUSE: assert property ($rose(mc_busy) |-> $past(op_start))
    else $error("busy without start");
  AST_NO_START: assert property (mc_busy |-> !op_start)
    else $error("start issued while busy");
  AST_HOLD: assert property (mc_busy |-> $stable({a_bank_select_high, a_bank_select_low,
    b_bank_select_high, b_bank_select_low, single_precision_select, alu_instruction_field}))
    else $error("controls moved while busy");
  AST_B_LOCK: assert property (mc_busy && load_b_en |->
    load_b_idx != fos_sel_to_idx(b_bank_select_high, b_bank_select_low))
    else $error("load into busy B register");
  AST_A_LOCK: assert property (mc_busy && load_a_en && !fos_is_sqrt(alu_instruction_field) |->
    load_a_idx != fos_sel_to_idx(a_bank_select_high, a_bank_select_low))
    else $error("load into busy A register");
endmodule

// file: dv/fp_input_operand_select_tb.sv
// Bench: controller and operand bank joined by fos_if, driven from the user side.
// Assumes a 50 MHz clock and a synchronous active-high reset.
module fp_input_operand_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fos_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic user_op_valid, user_op_alu, user_single, user_load_valid, user_load_bank_b, user_ready;
  logic operand_valid, operand_to_alu, mult_single, alu_single, mc_active;
  fos_instr_t user_instr;
  fos_idx_t user_a_idx, user_b_idx, user_load_idx;
  fos_word_t user_load_data, operand_a, operand_b, old;
  fos_word_t ea [4];
  fos_word_t eb [4];
  int n_errors = 0, tests_run = 0, cycles = 0;
  logic exp_sp = 1'b0;
  localparam logic [1:0] SEL_CODE [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
  always #10 clock = ~clock;
  fos_if pins ();
  fos_controller i_fos_controller (.clock(clock), .reset(reset), .pins(pins.ctl),
    .user_op_valid(user_op_valid), .user_op_alu(user_op_alu), .user_instr(user_instr),
    .user_single(user_single), .user_a_idx(user_a_idx), .user_b_idx(user_b_idx),
    .user_load_valid(user_load_valid), .user_load_bank_b(user_load_bank_b),
    .user_load_idx(user_load_idx), .user_load_data(user_load_data), .user_ready(user_ready));
  fos_operand_bank i_fos_operand_bank (.clock(clock), .reset(reset), .pins(pins.dev),
    .operand_a(operand_a), .operand_b(operand_b), .operand_valid(operand_valid),
    .operand_to_alu(operand_to_alu), .mult_single(mult_single), .alu_single(alu_single),
    .mc_active(mc_active));
  fos_assertions i_fos_assertions (.clock(clock), .reset(reset),
    .a_bank_select_low(pins.a_bank_select_low), .a_bank_select_high(pins.a_bank_select_high),
    .b_bank_select_low(pins.b_bank_select_low), .b_bank_select_high(pins.b_bank_select_high),
    .single_precision_select(pins.single_precision_select), .op_start(pins.op_start),
    .alu_instruction_field(pins.alu_instruction_field), .op_unit_alu(pins.op_unit_alu),
    .load_a_en(pins.load_a_en), .load_a_idx(pins.load_a_idx), .load_b_en(pins.load_b_en),
    .load_b_idx(pins.load_b_idx), .mc_busy(pins.mc_busy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic ld(input logic bank_b, input fos_idx_t idx, input fos_word_t data);
    {user_load_bank_b, user_load_idx, user_load_data, user_load_valid} = {bank_b, idx, data, 1'b1};
    if (bank_b) eb[idx] = data;
    else ea[idx] = data;
    @(negedge clock);
  endtask

  task automatic op(input logic alu, input fos_instr_t ins, input logic sp, input fos_idx_t ai,
                    input fos_idx_t bi, input logic mc);
    while (user_ready !== 1'b1) @(negedge clock);
    {user_op_alu, user_instr, user_single, user_a_idx, user_b_idx} = {alu, ins, sp, ai, bi};
    user_op_valid = 1'b1;
    @(negedge clock);
    {user_op_valid, user_load_valid} = 2'h0;
    chk({pins.a_bank_select_high, pins.a_bank_select_low}, SEL_CODE[ai]);
    chk({pins.b_bank_select_high, pins.b_bank_select_low}, SEL_CODE[bi]);
    @(negedge clock);
    chk(operand_valid, 1'b1);
    chk(operand_a, ea[ai]);
    chk(operand_b, eb[bi]);
    chk(operand_to_alu, alu);
    chk(alu ? alu_single : mult_single, alu ? ins[ALU_FMT_BIT] : sp);
    if (!alu) exp_sp = sp;
    chk(mult_single, exp_sp);
    @(negedge clock);
    chk(operand_valid, mc);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    {user_op_valid, user_op_alu, user_single, user_load_valid, user_load_bank_b} = 5'h00;
    {user_instr, user_a_idx, user_b_idx, user_load_idx, user_load_data} = '0;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      ld(1'b0, 2'(i), 32'hAAAA_0000 + 32'(i));
      ld(1'b1, 2'(i), 32'hBBBB_0000 + 32'(i));
    end
    user_load_valid = 1'b0;
    for (int i = 0; i < 4; i++) begin
      op(i[0], i[0] ? {i[1], 8'h01} : INSTR_ZERO, i[1], 2'(i), 2'(3 - i), 1'b0);
    end
    // Load and read of the same register on one edge
    {user_load_bank_b, user_load_idx, user_load_data, user_load_valid} = {3'h1, 32'h1234_5678, 1'b1};
    ea[1] = 32'h1234_5678;
    op(1'b0, INSTR_ZERO, 1'b1, 2'h1, 2'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      old = eb[2];
      op(1'b1, {1'b1, k ? OPC_SQRT : OPC_DIVIDE}, 1'b0, 2'h1, 2'h2, 1'b1);
      ld(1'b1, 2'h2, 32'hDEAD_0000);
      eb[2] = old;
      ld(1'b1, 2'h3, 32'hBEEF_0000 + 32'(k));
      ld(1'b0, 2'h0, 32'hCAFE_0000 + 32'(k));
      user_load_valid = 1'b0;
      repeat (3) begin
        chk(operand_valid & mc_active, 1'b1);
        chk(operand_a, ea[1]);
        chk(operand_b, old);
        chk(user_ready, 1'b0);
        @(negedge clock);
      end
      // Last reread is registered on the same edge where busy falls
      chk(operand_valid & ~mc_active, 1'b1);
      chk(operand_b, old);
      chk(user_ready, 1'b1);
      @(negedge clock);
      chk(operand_valid | mc_active, 1'b0);
      op(1'b0, INSTR_ZERO, 1'b0, 2'h0, 2'h2, 1'b0);
      op(1'b0, INSTR_ZERO, 1'b0, 2'h0, 2'h3, 1'b0);
    end
    complete_run();
  end
endmodule

// file: logic/fos_controller.sv
// Controller end: turns user requests into registered control and load pins.
// Assumes user requests come from logic on the same clock.
module fos_controller
  import fos_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  fos_if.ctl pins,
  input wire logic user_op_valid,
  input wire logic user_op_alu,
  input wire fos_pkg::fos_instr_t user_instr,
  input wire logic user_single,
  input wire fos_pkg::fos_idx_t user_a_idx,
  input wire fos_pkg::fos_idx_t user_b_idx,
  input wire logic user_load_valid,
  input wire logic user_load_bank_b,
  input wire fos_pkg::fos_idx_t user_load_idx,
  input wire fos_pkg::fos_word_t user_load_data,
  output logic user_ready
);
  import fos_pkg::*;

  typedef struct packed {
    logic [1:0] a_sel;
    logic [1:0] b_sel;
    logic sp;
    fos_instr_t instr;
    logic start;
    logic unit_alu;
    logic la_en;
    fos_idx_t la_idx;
    fos_word_t la_data;
    logic lb_en;
    fos_idx_t lb_idx;
    fos_word_t lb_data;
    logic lock;
    logic lock_a_on;
    fos_idx_t lock_a;
    fos_idx_t lock_b;
    logic [CNT_W-1:0] cnt;
  } fos_ctl_state_t;

  fos_ctl_state_t state_q;
  fos_ctl_state_t state_d;

  always_comb begin
    logic hit;
    state_d = state_q;
    hit = 1'b0;
    state_d.start = 1'b0;
    state_d.la_en = 1'b0;
    state_d.lb_en = 1'b0;
    if (state_q.lock) begin
      state_d.cnt = state_q.cnt - CNT_ONE;
      if (state_q.cnt == CNT_ONE) begin
        state_d.lock = 1'b0;
      end
    end else if (user_op_valid) begin
      // Selects then stay put for a multicycle operation
      state_d.a_sel = fos_idx_to_sel(user_a_idx); // see RQ10
      state_d.b_sel = fos_idx_to_sel(user_b_idx);
      state_d.sp = user_single;
      state_d.instr = user_instr;
      state_d.unit_alu = user_op_alu;
      state_d.start = 1'b1;
      if (user_op_alu && fos_is_multicycle(user_instr)) begin
        // Square root uses only a B register; dividend any A
        state_d.lock = 1'b1; // see RQ9 RQ10
        state_d.lock_a_on = ~fos_is_sqrt(user_instr);
        state_d.lock_a = user_a_idx;
        state_d.lock_b = user_b_idx;
        state_d.cnt = MC_CYCLES;
      end
    end
    if (user_load_valid && state_q.lock) begin
      // Registers held by a multicycle operation are never loaded
      hit = user_load_bank_b ? (user_load_idx == state_q.lock_b) : // see RQ5 RQ7
            (state_q.lock_a_on && (user_load_idx == state_q.lock_a));
    end
    if (user_load_valid && !hit) begin
      if (user_load_bank_b) begin
        state_d.lb_en = 1'b1;
        state_d.lb_idx = user_load_idx;
        state_d.lb_data = user_load_data;
      end else begin
        state_d.la_en = 1'b1;
        state_d.la_idx = user_load_idx;
        state_d.la_data = user_load_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
      user_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      user_ready <= ~state_d.lock;
    end
  end

  assign pins.a_bank_select_high = state_q.a_sel[1];
  assign pins.a_bank_select_low = state_q.a_sel[0];
  assign pins.b_bank_select_high = state_q.b_sel[1];
  assign pins.b_bank_select_low = state_q.b_sel[0];
  assign pins.single_precision_select = state_q.sp;
  assign pins.alu_instruction_field = state_q.instr;
  assign pins.op_start = state_q.start;
  assign pins.op_unit_alu = state_q.unit_alu;
  assign pins.load_a_en = state_q.la_en;
  assign pins.load_a_idx = state_q.la_idx;
  assign pins.load_a_data = state_q.la_data;
  assign pins.load_b_en = state_q.lb_en;
  assign pins.load_b_idx = state_q.lb_idx;
  assign pins.load_b_data = state_q.lb_data;
endmodule

// file: logic/fos_if.sv
// Control and data pins between the external controller and the operand bank.
// Assumes both ends run on the same clock; all signals are plain levels.
interface fos_if;
  import fos_pkg::*;
  logic a_bank_select_low;
  logic a_bank_select_high;
  logic b_bank_select_low;
  logic b_bank_select_high;
  logic single_precision_select;
  fos_instr_t alu_instruction_field;
  logic op_start;
  logic op_unit_alu;
  logic load_a_en;
  fos_idx_t load_a_idx;
  fos_word_t load_a_data;
  logic load_b_en;
  fos_idx_t load_b_idx;
  fos_word_t load_b_data;
  logic mc_busy;

  modport dev (
    input a_bank_select_low, a_bank_select_high, b_bank_select_low, b_bank_select_high,
    input single_precision_select, alu_instruction_field, op_start, op_unit_alu,
    input load_a_en, load_a_idx, load_a_data, load_b_en, load_b_idx, load_b_data,
    output mc_busy
  );
  modport ctl (
    output a_bank_select_low, a_bank_select_high, b_bank_select_low, b_bank_select_high,
    output single_precision_select, alu_instruction_field, op_start, op_unit_alu,
    output load_a_en, load_a_idx, load_a_data, load_b_en, load_b_idx, load_b_data,
    input mc_busy
  );
endinterface

// file: logic/fos_operand_bank.sv
// Operand register banks A and B with read selection and format capture.
// Assumes the controller drives the pins from flops on the same clock.
// What this block and its controller do
// RQ1: Select codes 10/11 feed registers 0/1
// RQ2: Select codes 00/01 feed registers 2/3
// RQ3: Selects registered; same-edge loads feed directly
// RQ4: Multicycle operation ignores selects, sequences internally
// RQ5: Controller loads only registers not in use
// RQ6: Ordinary operations read operands one cycle
// RQ7: No 32-bit load into a register held by a multicycle operation
// RQ8: Only divide and square root are multicycle
// RQ9: Dividend any A, divisor/root any B
// RQ10: Multicycle operand registers held until done
// RQ11: Multiplier format single when select high
// RQ12: Format sampled on multiplier operand read
// RQ13: Format changes ignored between operand reads
// RQ14: ALU format taken from instruction field
module fos_operand_bank
  import fos_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  fos_if.dev pins,
  output fos_pkg::fos_word_t operand_a,
  output fos_pkg::fos_word_t operand_b,
  output logic operand_valid,
  output logic operand_to_alu,
  output logic mult_single,
  output logic alu_single,
  output logic mc_active
);
  import fos_pkg::*;

  typedef struct packed {
    fos_bank_t a_bank;
    fos_bank_t b_bank;
    fos_word_t op_a;
    fos_word_t op_b;
    logic op_valid;
    logic to_alu;
    logic mult_sp;
    logic alu_sp;
    logic busy;
    logic [CNT_W-1:0] cnt;
    fos_idx_t hold_a;
    fos_idx_t hold_b;
  } fos_dev_state_t;

  fos_dev_state_t state_q;
  fos_dev_state_t state_d;

  always_comb begin
    fos_idx_t sel_a;
    fos_idx_t sel_b;
    logic read_now;
    state_d = state_q;
    sel_a = IDX_ZERO;
    sel_b = IDX_ZERO;
    read_now = 1'b0;
    state_d.op_valid = 1'b0; // see RQ6
    if (pins.load_a_en) begin
      state_d.a_bank[pins.load_a_idx] = pins.load_a_data;
    end
    if (pins.load_b_en) begin
      state_d.b_bank[pins.load_b_idx] = pins.load_b_data;
    end
    if (state_q.busy) begin
      // Selects are ignored; the held registers are reread each cycle
      sel_a = state_q.hold_a; // see RQ4
      sel_b = state_q.hold_b;
      read_now = 1'b1;
      state_d.cnt = state_q.cnt - CNT_ONE;
      if (state_q.cnt == CNT_ONE) begin
        state_d.busy = 1'b0;
      end
    end else if (pins.op_start) begin
      sel_a = fos_sel_to_idx(pins.a_bank_select_high, pins.a_bank_select_low); // see RQ1 RQ2
      sel_b = fos_sel_to_idx(pins.b_bank_select_high, pins.b_bank_select_low); // see RQ1 RQ2
      read_now = 1'b1;
      state_d.to_alu = pins.op_unit_alu;
      if (pins.op_unit_alu) begin
        state_d.alu_sp = pins.alu_instruction_field[ALU_FMT_BIT]; // see RQ14
        if (fos_is_multicycle(pins.alu_instruction_field)) begin // see RQ8
          state_d.busy = 1'b1;
          state_d.cnt = MC_CYCLES - CNT_ONE;
          state_d.hold_a = sel_a;
          state_d.hold_b = sel_b;
        end
      end else begin
        // Sampled only on an operand read, held otherwise
        state_d.mult_sp = pins.single_precision_select; // see RQ11 RQ12 RQ13
      end
    end
    if (read_now) begin
      state_d.op_valid = 1'b1;
      // Direct operand feed from a load on the same edge
      if (pins.load_a_en && (pins.load_a_idx == sel_a)) begin // see RQ3
        state_d.op_a = pins.load_a_data;
      end else begin
        state_d.op_a = state_q.a_bank[sel_a];
      end
      if (pins.load_b_en && (pins.load_b_idx == sel_b)) begin // see RQ3
        state_d.op_b = pins.load_b_data;
      end else begin
        state_d.op_b = state_q.b_bank[sel_b];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pins.mc_busy = state_q.busy;
  assign operand_a = state_q.op_a;
  assign operand_b = state_q.op_b;
  assign operand_valid = state_q.op_valid;
  assign operand_to_alu = state_q.to_alu;
  assign mult_single = state_q.mult_sp;
  assign alu_single = state_q.alu_sp;
  assign mc_active = state_q.busy;
endmodule

// file: logic/fos_pkg.sv
// Shared constants and types for the operand register bank and its controller.
// Assumes both ends share one clock and a synchronous active-high reset.
package fos_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 2;
  localparam int unsigned REGS = 4;
  localparam int unsigned INSTR_W = 9;
  localparam int unsigned CNT_W = 4;
  // Multicycle division and square root operand read length, in cycles
  localparam logic [CNT_W-1:0] MC_CYCLES = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // Instruction field bit that selects single precision on the ALU
  localparam int unsigned ALU_FMT_BIT = 8;
  // Opcode part of the instruction field and the two multicycle opcodes
  localparam int unsigned OPC_HI = 7;
  localparam int unsigned OPC_LO = 0;
  localparam logic [7:0] OPC_DIVIDE = 8'h40;
  localparam logic [7:0] OPC_SQRT = 8'h41;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_ZERO = 2'h0;
  localparam logic [INSTR_W-1:0] INSTR_ZERO = 9'h000;

  typedef logic [DATA_W-1:0] fos_word_t;
  typedef logic [IDX_W-1:0] fos_idx_t;
  typedef logic [INSTR_W-1:0] fos_instr_t;
  typedef logic [REGS-1:0][DATA_W-1:0] fos_bank_t;

  // Select code 10 -> reg 0, 11 -> 1, 00 -> 2, 01 -> 3
  function automatic fos_idx_t fos_sel_to_idx(input logic high, input logic low);
    fos_sel_to_idx = {~high, low};
  endfunction

  // Inverse mapping, used by the controller to drive the select pins
  function automatic logic [1:0] fos_idx_to_sel(input fos_idx_t idx);
    fos_idx_to_sel = {~idx[1], idx[0]};
  endfunction

  function automatic logic fos_is_multicycle(input fos_instr_t instr);
    fos_is_multicycle = (instr[OPC_HI:OPC_LO] == OPC_DIVIDE) ||
                        (instr[OPC_HI:OPC_LO] == OPC_SQRT);
  endfunction

  function automatic logic fos_is_sqrt(input fos_instr_t instr);
    fos_is_sqrt = (instr[OPC_HI:OPC_LO] == OPC_SQRT);
  endfunction
endpackage
